// ---- psi_pkg.sv ----
package psi_pkg;

  // live status levels from the transceiver core
  typedef struct packed {
    logic remote_fault;
    logic jabber;
    logic an_complete;
    logic loopback;
    logic full_duplex;
    logic speed10;
    logic link_up;
  } psi_phy_stat_t;

  // event sources that are not derived from the status levels
  typedef struct packed {
    logic lq_event;
    logic energy_detect;
    logic fc_half_full;
    logic rx_half_full;
  } psi_evt_src_t;

  // held write request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } psi_wr_req_t;

endpackage

// ---- psi_regs.svh ----
`ifndef PSI_REGS_SVH
`define PSI_REGS_SVH

// register indices; byte address is four times the index
`define PSI_IDX_BASIC_STATUS 8'h01
`define PSI_IDX_STATUS_SUMMARY 8'h10
`define PSI_IDX_INT_CONTROL 8'h11
`define PSI_IDX_EVENT_STATUS 8'h12
`define PSI_IDX_IRQ_STATUS 8'h18
`define PSI_IDX_IRQ_MASK 8'h19

// interrupt control fields
`define PSI_ICR_OUT_SEL 0
`define PSI_ICR_EVT_EN 1
`define PSI_ICR_TEST_INT 2
`define PSI_ICR_WIDTH 3
`define PSI_ICR_RESET 3'h0

// event vector width and reset values
`define PSI_EVT_WIDTH 8
`define PSI_EVT_RESET 8'h00
`define PSI_EN_RESET 8'h00
`define PSI_MASK_RESET 8'h00

// basic status field positions
`define PSI_BSR_JABBER 1
`define PSI_BSR_LINK 2
`define PSI_BSR_REMOTE_FAULT 4

// bus responses
`define PSI_RESP_OKAY 2'h0
`define PSI_RESP_SLVERR 2'h2

`endif

// ---- psi_top.sv ----
`include "psi_regs.svh"

// Summary of operation
// R1: remote fault latches on partner fault; cleared by basic status read or reset
// R2: jabber bit mirrors basic status jabber; summary read leaves it alone
// R3: auto-negotiation complete bit follows the core, zero after reset
// R4: loopback bit reads one while loopback is enabled
// R5: duplex bit reads one for full duplex, from negotiation or forcing
// R6: software trusts duplex and speed only with link and settled negotiation
// R7: speed bit reads one at 10 Mb/s, zero at 100 Mb/s
// R8: link bit mirrors basic status link; summary read leaves it alone
// R9: control bits 15:3 ignore writes and read zero
// R10: test interrupt bit forces the interrupt while set
// R11: global enable gates event interrupts with per-event enables
// R12: output select makes shared pin an interrupt output, else power-down input
// R13: eight event sources each with its own enable bit
// R14: event flags clear when event status register is read
// R15: event flags set even when their interrupt is disabled
// R16: summary bit 7 shows pending interrupt, cleared via event status read
// R17: pin asserts when selected and test or enabled pending event exists
module psi_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // transceiver core status and events
  input wire psi_pkg::psi_phy_stat_t phy_stat,
  input wire psi_pkg::psi_evt_src_t evt_src,
  // shared power-down / interrupt pin
  input wire logic powerdown_or_interrupt_pin_i,
  output logic powerdown_or_interrupt_pin_o,
  output logic powerdown_or_interrupt_pin_oe,
  // power-down request from the pin, active high
  output logic powerdown_req,
  // software interrupt
  output logic irq
);

  // address decode shared by the read and write paths
  // low address bits must be zero: a misaligned access misses every
  // register and gets an error response
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [7:0] idx);
    hit = (addr[ADDR_W-1:2] == idx[ADDR_W-3:0]) && (addr[1:0] == 2'h0);
  endfunction

  // bus state
  logic aw_full_reg, aw_full_next;
  logic w_full_reg, w_full_next;
  logic awready_reg, wready_reg, bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  psi_pkg::psi_wr_req_t wr_req_reg, wr_req_next;

  // register state
  logic [`PSI_ICR_WIDTH-1:0] icr_reg, icr_next;
  logic [`PSI_EVT_WIDTH-1:0] evt_reg, evt_next;
  logic [`PSI_EVT_WIDTH-1:0] en_reg, en_next;
  logic [`PSI_EVT_WIDTH-1:0] irq_st_reg, irq_st_next;
  logic [`PSI_EVT_WIDTH-1:0] mask_reg, mask_next;
  logic rf_reg, rf_next;
  logic [6:0] prev_reg;
  logic irq_reg, pin_o_reg, pin_oe_reg, pd_req_reg;
  logic pin_s1_reg, pin_s2_reg;

  // handshakes
  // wr_do waits for a free response slot, so a new write can never
  // overwrite a response the master has not taken yet
  wire aw_fire = s_axi_awvalid & awready_reg;
  wire w_fire = s_axi_wvalid & wready_reg;
  wire ar_fire = s_axi_arvalid & arready_reg;
  wire wr_do = aw_full_reg & w_full_reg & ~bvalid_reg;

  // write request capture, address and data in either order
  always_comb begin
    wr_req_next = wr_req_reg;
    if (aw_fire) begin
      wr_req_next.addr = s_axi_awaddr[7:0];
    end
    if (w_fire) begin
      wr_req_next.data = s_axi_wdata;
      wr_req_next.strb = s_axi_wstrb;
    end
  end

  // write slot bookkeeping
  // each slot holds one item and its ready drops once it fills, so the
  // master may hand over address and data in either order
  assign aw_full_next = (aw_full_reg | aw_fire) & ~wr_do;
  assign w_full_next = (w_full_reg | w_fire) & ~wr_do;
  assign bvalid_next = wr_do | (bvalid_reg & ~s_axi_bready);

  // write decode of the held request
  wire [ADDR_W-1:0] wa = wr_req_reg.addr[ADDR_W-1:0];
  wire wr_bsr = wr_do & hit(wa, `PSI_IDX_BASIC_STATUS);
  wire wr_sum = wr_do & hit(wa, `PSI_IDX_STATUS_SUMMARY);
  wire wr_icr = wr_do & hit(wa, `PSI_IDX_INT_CONTROL);
  wire wr_evt = wr_do & hit(wa, `PSI_IDX_EVENT_STATUS);
  wire wr_ist = wr_do & hit(wa, `PSI_IDX_IRQ_STATUS);
  wire wr_msk = wr_do & hit(wa, `PSI_IDX_IRQ_MASK);
  wire wr_hit = wr_bsr | wr_sum | wr_icr | wr_evt | wr_ist | wr_msk;
  wire lane0 = wr_req_reg.strb[0];
  wire [7:0] wbyte = wr_req_reg.data[7:0];

  // response code, unmapped writes get slverr
  assign bresp_next = wr_do ? (wr_hit ? `PSI_RESP_OKAY : `PSI_RESP_SLVERR)
                            : bresp_reg;

  // read decode at the address handshake
  // decoding at the handshake edge makes clear-on-read act once per read,
  // in the same edge that captures the old value into rdata
  wire rd_bsr = ar_fire & hit(s_axi_araddr, `PSI_IDX_BASIC_STATUS);
  wire rd_sum = ar_fire & hit(s_axi_araddr, `PSI_IDX_STATUS_SUMMARY);
  wire rd_icr = ar_fire & hit(s_axi_araddr, `PSI_IDX_INT_CONTROL);
  wire rd_evt = ar_fire & hit(s_axi_araddr, `PSI_IDX_EVENT_STATUS);
  wire rd_ist = ar_fire & hit(s_axi_araddr, `PSI_IDX_IRQ_STATUS);
  wire rd_msk = ar_fire & hit(s_axi_araddr, `PSI_IDX_IRQ_MASK);
  wire rd_hit = rd_bsr | rd_sum | rd_icr | rd_evt | rd_ist | rd_msk;
  assign rvalid_next = ar_fire | (rvalid_reg & ~s_axi_rready);

  // event detection from the previous status sample
  // prev_reg resets to zero, so a level already high when reset ends
  // shows up as a change or rise on the first edge
  wire [6:0] prev_now = {phy_stat.link_up, phy_stat.speed10,
                         phy_stat.full_duplex, phy_stat.an_complete,
                         evt_src.energy_detect, evt_src.fc_half_full,
                         evt_src.rx_half_full};
  wire link_chg = prev_now[6] ^ prev_reg[6];
  wire spd_chg = prev_now[5] ^ prev_reg[5];
  wire dup_chg = prev_now[4] ^ prev_reg[4];
  wire anc_rise = prev_now[3] & ~prev_reg[3];
  wire ed_chg = prev_now[2] ^ prev_reg[2];
  wire fhf_rise = prev_now[1] & ~prev_reg[1];
  wire rhf_rise = prev_now[0] & ~prev_reg[0];

  // event vector, bit 7 down to 0: lq, ed, link, spd, dup, anc, fhf, rhf
  wire [`PSI_EVT_WIDTH-1:0] ev_set = {evt_src.lq_event, ed_chg, link_chg,
                                      spd_chg, dup_chg, anc_rise,
                                      fhf_rise, rhf_rise}; // R13

  // event flags: set always, clear on read, set wins
  // an event in the edge of a read is kept: the read returns the old
  // flags and the new one stays pending for the next read
  assign evt_next = (evt_reg & ~{`PSI_EVT_WIDTH{rd_evt}}) | ev_set; // R14 R15

  // per-event enables in the low byte of the event register
  assign en_next = (wr_evt & lane0) ? wbyte : en_reg; // R13

  // interrupt control, only the low three bits are stored
  // upper write data has nowhere to go, so reserved bits cannot stick
  assign icr_next = (wr_icr & lane0) ? wbyte[`PSI_ICR_WIDTH-1:0]
                                     : icr_reg; // R9

  // remote fault latch, cleared by a basic status read, set wins
  // a one-cycle fault notice must stay visible until software has read
  // the basic status word
  assign rf_next = (rf_reg & ~rd_bsr) | phy_stat.remote_fault; // R1

  // sticky software interrupt status, write one to clear, set wins
  // this status and mask pair feeds irq only and is independent of the
  // pin path, so software may poll one while the other is in use
  wire [`PSI_EVT_WIDTH-1:0] ist_clr = (wr_ist & lane0) ? wbyte
                                                        : `PSI_EVT_RESET;
  assign irq_st_next = (irq_st_reg & ~ist_clr) | ev_set;
  assign mask_next = (wr_msk & lane0) ? wbyte : mask_reg;

  // pending interrupt: forced by test bit or enabled pending events
  // pending is combinational so a summary read shows it at once; the
  // registered pin follows one cycle later
  wire test_on = icr_reg[`PSI_ICR_TEST_INT]; // R10
  wire evt_ok = icr_reg[`PSI_ICR_EVT_EN] & |(evt_reg & en_reg); // R11
  wire pending = test_on | evt_ok; // R16 R17
  wire out_sel = icr_reg[`PSI_ICR_OUT_SEL];

  // summary register image, upper bits read zero
  wire [31:0] sum_word = {24'h000000, pending, rf_reg,
                          phy_stat.jabber, // R2
                          phy_stat.an_complete, // R3
                          phy_stat.loopback, // R4
                          phy_stat.full_duplex, // R5
                          phy_stat.speed10, // R7
                          phy_stat.link_up}; // R8

  // basic status image
  logic [31:0] bsr_word;
  always_comb begin
    bsr_word = 32'h00000000;
    bsr_word[`PSI_BSR_JABBER] = phy_stat.jabber;
    bsr_word[`PSI_BSR_LINK] = phy_stat.link_up;
    bsr_word[`PSI_BSR_REMOTE_FAULT] = rf_reg;
  end

  // read data selection
  wire [31:0] icr_word = {29'h0000000, icr_reg}; // R9
  wire [31:0] evt_word = {16'h0000, evt_reg, en_reg};
  wire [31:0] ist_word = {24'h000000, irq_st_reg};
  wire [31:0] msk_word = {24'h000000, mask_reg};
  wire [31:0] rd_word = rd_bsr ? bsr_word :
                        rd_sum ? sum_word :
                        rd_icr ? icr_word :
                        rd_evt ? evt_word :
                        rd_ist ? ist_word :
                        rd_msk ? msk_word : 32'h00000000;
  wire [1:0] rd_resp = rd_hit ? `PSI_RESP_OKAY : `PSI_RESP_SLVERR;

  // write channel flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `PSI_RESP_OKAY;
      wr_req_reg <= '0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awready_reg <= ~aw_full_next & ~bvalid_next;
      wready_reg <= ~w_full_next & ~bvalid_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      wr_req_reg <= wr_req_next;
    end
  end

  // read channel flops
  // rdata loads only on the handshake, so it stands unchanged while
  // rvalid waits for rready
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `PSI_RESP_OKAY;
    end else begin
      arready_reg <= ~rvalid_next;
      rvalid_reg <= rvalid_next;
      if (ar_fire) begin
        rdata_reg <= rd_word;
        rresp_reg <= rd_resp;
      end
    end
  end

  // control and status registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      icr_reg <= `PSI_ICR_RESET;
      evt_reg <= `PSI_EVT_RESET;
      en_reg <= `PSI_EN_RESET;
      irq_st_reg <= `PSI_EVT_RESET;
      mask_reg <= `PSI_MASK_RESET;
      rf_reg <= 1'b0;
    end else begin
      icr_reg <= icr_next;
      evt_reg <= evt_next;
      en_reg <= en_next;
      irq_st_reg <= irq_st_next;
      mask_reg <= mask_next;
      rf_reg <= rf_next;
    end
  end

  // previous status sample; first edge after reset compares against zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_reg <= 7'h00;
    end else begin
      prev_reg <= prev_now;
    end
  end

  // pin input synchroniser, active-low power-down level on the pin
  // both stages reset to the idle high level so no false power-down
  // request follows reset; only the second stage feeds logic
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_reg <= 1'b1;
      pin_s2_reg <= 1'b1;
    end else begin
      pin_s1_reg <= powerdown_or_interrupt_pin_i;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // shared pin direction and level, interrupt driven active low
  // direction and level change on the same edge, so the pin is never
  // driven with a stale level when the direction flips
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_oe_reg <= 1'b0;
      pin_o_reg <= 1'b1;
      pd_req_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      pin_oe_reg <= out_sel; // R12
      pin_o_reg <= ~(out_sel & pending); // R17
      pd_req_reg <= ~out_sel & ~pin_s2_reg; // R12
      irq_reg <= |(irq_st_next & mask_next);
    end
  end

  // outputs straight from flops
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign powerdown_or_interrupt_pin_o = pin_o_reg;
  assign powerdown_or_interrupt_pin_oe = pin_oe_reg;
  assign powerdown_req = pd_req_reg;
  assign irq = irq_reg;

endmodule

// ---- psi_top_asserts.sv ----
module psi_top_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // core status and pin
  input wire psi_pkg::psi_phy_stat_t phy_stat,
  input wire logic powerdown_or_interrupt_pin_o,
  input wire logic powerdown_or_interrupt_pin_oe,
  input wire logic powerdown_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic [7:0] aw_q, ar_q;
  logic [3:0] wd_q;
  logic [2:0] ctl_q;
  logic bv_q, ctl_wr, rf_q, bsr_rd;
  // basic status read clears the fault shadow
  assign bsr_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04;
  // control write lands when bvalid first shows
  assign ctl_wr = s_axi_bvalid && !bv_q && aw_q == 8'h44 && wd_q[3];
  // shadow of the control register from observed writes
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {aw_q, ar_q, wd_q, ctl_q, bv_q, rf_q} <= '0;
    end else begin
      bv_q <= s_axi_bvalid;
      rf_q <= (rf_q && !bsr_rd) || phy_stat.remote_fault;
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
        wd_q <= {s_axi_wstrb[0], s_axi_wdata[2:0]};
      end
      if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
      if (ctl_wr) ctl_q <= wd_q[2:0];
    end
  end
  sum_mirror_a: assert property (
    $rose(s_axi_rvalid) && ar_q == 8'h40
    |-> s_axi_rdata[5:0] == $past(phy_stat[5:0]))
    else $error("summary bits differ from core status");
  fault_latch_a: assert property (
    $rose(s_axi_rvalid) && ar_q == 8'h40
    |-> s_axi_rdata[6] == $past(rf_q))
    else $error("remote fault not latched");
  ctl_readback_a: assert property (
    $rose(s_axi_rvalid) && ar_q == 8'h44
    |-> s_axi_rdata == {29'h0, ctl_q}) else $error("control readback wrong");
  test_force_a: assert property (
    ctl_q[2] && ctl_q[0] |-> !powerdown_or_interrupt_pin_o)
    else $error("forced interrupt missing");
  event_gate_a: assert property (
    !(ctl_q[0] && (ctl_q[1] || ctl_q[2])) |-> powerdown_or_interrupt_pin_o)
    else $error("interrupt without enable");
  pin_dir_a: assert property (
    powerdown_or_interrupt_pin_oe == ctl_q[0])
    else $error("pin direction wrong");
  pd_input_a: assert property (
    powerdown_req |-> !powerdown_or_interrupt_pin_oe)
    else $error("power-down while pin is output");
  pin_active_a: assert property (
    !powerdown_or_interrupt_pin_o |-> powerdown_or_interrupt_pin_oe)
    else $error("interrupt on undriven pin");
endmodule

bind psi_top psi_top_asserts chk_u (.sys_clk, .rst_b, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .phy_stat, .powerdown_or_interrupt_pin_o,
  .powerdown_or_interrupt_pin_oe, .powerdown_req);

// ---- psi_top_bench.sv ----
module psi_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst_b, irq, powerdown_req;
  logic [7:0] s_axi_awaddr, s_axi_araddr, en;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic powerdown_or_interrupt_pin_i, powerdown_or_interrupt_pin_o;
  logic powerdown_or_interrupt_pin_oe;
  logic [6:0] ps;
  psi_pkg::psi_phy_stat_t phy_stat;
  psi_pkg::psi_evt_src_t evt_src;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  int unsigned seed;

  psi_top dut_u (.sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .phy_stat, .evt_src, .powerdown_or_interrupt_pin_i,
    .powerdown_or_interrupt_pin_o, .powerdown_or_interrupt_pin_oe,
    .powerdown_req, .irq);

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // cut a hang short
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      $display("timeout at %0t", $time);
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // summary word: pending, fault latch, live status
  function automatic logic [31:0] exp_sum(input logic [6:0] s, input logic p);
    return {24'h0, p, s};
  endfunction

  // event word: one flag over the enables
  function automatic logic [31:0] exp_evt(input int k, input logic [7:0] e);
    return {16'h0, 8'h01 << k, e};
  endfunction

  // write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // one-cycle stimulus on event source k
  task automatic pulse(input int k);
    logic [7:0] v;
    logic [6:0] x;
    v = 8'h01 << k;
    x = {2'b00, v[2], 1'b0, v[3], v[4], v[5]};
    @(posedge sys_clk);
    evt_src <= {v[7], v[6], v[1], v[0]};
    phy_stat <= phy_stat ^ x;
    @(posedge sys_clk);
    evt_src <= '0;
    phy_stat <= phy_stat ^ x;
    repeat (2) @(posedge sys_clk);
  endtask

  initial begin
    seed = $urandom(32'hCD4AF5D6);
    rst_b = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_rready = 1'b0;
    phy_stat = '0;
    evt_src = '0;
    powerdown_or_interrupt_pin_i = 1'b1;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(8'h44);
    chk32(rd_d, 32'h0);
    rd(8'h40);
    chk32(rd_d, 32'h0);
    rd(8'h64);
    chk32(rd_d, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      ps = 7'($urandom) & 7'h3F;
      @(posedge sys_clk);
      phy_stat <= ps;
      rd(8'h40);
      chk32(rd_d, exp_sum(ps, 1'b0));
      if (ps[0] && ps[4]) chk32({30'h0, rd_d[2:1]}, {30'h0, ps[2:1]});
      rd(8'h40);
      chk32(rd_d, exp_sum(ps, 1'b0));
    end
    @(posedge sys_clk);
    phy_stat <= 7'h40;
    @(posedge sys_clk);
    phy_stat <= 7'h00;
    rd(8'h40);
    chk32(rd_d, exp_sum(7'h40, 1'b0));
    rd(8'h04);
    chk32(rd_d, 32'h00000010);
    rd(8'h40);
    chk32(rd_d, exp_sum(7'h00, 1'b0));
    $display("test status done");
    wr(8'h44, 32'hFFFFFFF8, 4'hF);
    rd(8'h44);
    chk32(rd_d, 32'h0);
    wr(8'h44, 32'h7, 4'hE);
    rd(8'h44);
    chk32(rd_d, 32'h0);
    wr(8'h40, 32'hFF, 4'hF);
    chk32({30'h0, rsp}, 32'h0);
    wr(8'h44, 32'h5, 4'hF);
    rd(8'h40);
    chk32(rd_d, exp_sum(7'h00, 1'b1));
    chk1(powerdown_or_interrupt_pin_o, 1'b0);
    chk1(powerdown_or_interrupt_pin_oe, 1'b1);
    wr(8'h44, 32'h1, 4'hF);
    repeat (2) @(posedge sys_clk);
    chk1(powerdown_or_interrupt_pin_o, 1'b1);
    wr(8'h44, 32'h0, 4'hF);
    powerdown_or_interrupt_pin_i <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk1(powerdown_or_interrupt_pin_o, 1'b1);
    chk1(powerdown_or_interrupt_pin_oe, 1'b0);
    chk1(powerdown_req, 1'b1);
    powerdown_or_interrupt_pin_i <= 1'b1;
    $display("test control done");
    rd(8'h48);
    for (int k = 0; k < 8; k++) begin
      en = 8'($urandom) | (8'h01 << k);
      wr(8'h48, {24'h0, en}, 4'hF);
      wr(8'h44, 32'h1, 4'hF);
      pulse(k);
      chk1(powerdown_or_interrupt_pin_o, 1'b1);
      wr(8'h44, 32'h3, 4'hF);
      repeat (2) @(posedge sys_clk);
      chk1(powerdown_or_interrupt_pin_o, 1'b0);
      rd(8'h40);
      chk32(rd_d, exp_sum(7'h00, 1'b1));
      rd(8'h48);
      chk32(rd_d, exp_evt(k, en));
      rd(8'h48);
      chk32(rd_d, {24'h0, en});
      rd(8'h40);
      chk32(rd_d, exp_sum(7'h00, 1'b0));
      repeat (2) @(posedge sys_clk);
      chk1(powerdown_or_interrupt_pin_o, 1'b1);
    end
    $display("test events done");
    chk1(irq, 1'b0);
    wr(8'h64, 32'hFF, 4'hF);
    @(posedge sys_clk);
    chk1(irq, 1'b1);
    wr(8'h60, 32'h0F, 4'hF);
    rd(8'h60);
    chk32(rd_d, 32'hF0);
    wr(8'h60, 32'hF0, 4'hF);
    @(posedge sys_clk);
    chk1(irq, 1'b0);
    wr(8'h70, 32'h1, 4'hF);
    chk32({30'h0, rsp}, 32'h2);
    rd(8'h70);
    chk32({30'h0, rsp}, 32'h2);
    chk32(rd_d, 32'h0);
    $display("test irq done");
    conclude();
  end
endmodule
